// ### sps_pkg.sv
package sps_pkg;
   localparam int BYTE_BITS = 8;
   localparam int SYNC_W = 4;
   localparam int SYNC_SCK = 0;
   localparam int SYNC_MOSI = 1;
   localparam int SYNC_MISO = 2;
   localparam int SYNC_NSS = 3;
   localparam int MODE_HI_BIT = 1;
   localparam int MODE_LO_BIT = 0;
   localparam logic [1:0] SEL_3WIRE = 2'h0;
   localparam logic [1:0] SEL_4WIRE_IN = 2'h1;
   localparam logic [1:0] SEL_MODE_RST = 2'h1;
   localparam logic PORT_EN_RST = 1'h0;
   localparam logic MASTER_EN_RST = 1'h0;
   localparam logic MODE_FAULT_RST = 1'h0;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SCK_HALF_NS = 80;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### sps_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sps_sync #(
   parameter int W = 4
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= async_i[g];
               sync_q <= meta_q;
            end
         end
         assign sync_o[g] = sync_q;
      end
   endgenerate
endmodule
`default_nettype wire

// ### sps_port.sv
// Function
// (R1) Master drives data-out; slave takes it in
// (R2) Data goes most significant bit first
// (R3) Master takes data-in; slave drives it
// (R4) Data-in floats when disabled or unselected
// (R5) 3-wire slave drives data-in from top bit
// (R6) Master makes serial clock; slave receives it
// (R7) Unselected 4-wire slave ignores serial clock
// (R8) Mode 00: 3-wire, slave always selected
// (R9) Mode 01: select is input, low selects
// (R10) Master in mode 01 drops on select fall
// (R11) Mode 1x: select output equals low bit
// (R12) Select routed to pin except in 3-wire
// (R13) 3-wire slave must be alone on bus
// (R14) Mode fault clears enables, sets fault flag
// (R15) Select fall resets 4-wire slave bit counter
// (R16) Master only while master enable set
`timescale 1ns/1ps
`default_nettype none
module sps_port #(
   parameter int SCK_HALF = sps_pkg::SCK_HALF_CYC
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic cfg_wr,
   input wire logic cfg_port_enable,
   input wire logic cfg_master_enable,
   input wire logic [1:0] cfg_select_mode,
   input wire logic mode_fault_clr,
   output logic port_enable_bit,
   output logic master_enable_bit,
   output logic [1:0] select_mode_field,
   output logic mode_fault_flag,
   input wire logic tx_load,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_n,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_n,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_n,
   input wire logic nss_i,
   output logic nss_o,
   output logic nss_oe_n,
   output logic nss_routed
);
   logic [sps_pkg::SYNC_W-1:0] sync_s;
   logic port_en_q, mst_en_q, mode_fault_flag_q;
   logic [1:0] mode_q;
   logic sck_d_q, nss_d_q;
   logic [7:0] sh_q, txb_q, rxd_q;
   logic sh_full_q, txb_full_q, bit_q, rxv_q;
   logic txr_q;
   logic [2:0] cnt_q;
   logic [15:0] div_q;
   logic sck_q;
   logic mosi_q, mosi_oe_n_q, miso_q, miso_oe_n_q, sck_oe_n_q;
   logic nss_q, nss_oe_n_q, routed_q;
   logic sck_s, nss_s, din, mst, slv, sel, s_rise, s_fall, m_wrap, rise, fall;
   logic nss_fall, fault, load_sh, done;

   sps_sync #(.W(sps_pkg::SYNC_W)) u_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .async_i({nss_i, miso_i, mosi_i, sck_i}),
      .sync_o(sync_s)
   );

   assign sck_s = sync_s[sps_pkg::SYNC_SCK];
   assign nss_s = sync_s[sps_pkg::SYNC_NSS];
   assign mst = port_en_q & mst_en_q; // (R16)
   assign slv = port_en_q & ~mst_en_q; // (R16)
   // Any mode but 01 leaves the slave selected; 1x as slave is unsupported use
   assign sel = ~((mode_q == sps_pkg::SEL_4WIRE_IN) & nss_s); // (R8) (R9)
   assign nss_fall = nss_d_q & ~nss_s;
   assign s_rise = slv & sel & sck_s & ~sck_d_q; // (R6) (R7)
   assign s_fall = slv & sel & ~sck_s & sck_d_q; // (R6) (R7)
   assign m_wrap = mst & sh_full_q & (div_q == 16'(SCK_HALF - 1));
   assign rise = s_rise | (m_wrap & ~sck_q);
   assign fall = s_fall | (m_wrap & sck_q);
   assign din = mst ? sync_s[sps_pkg::SYNC_MISO] : sync_s[sps_pkg::SYNC_MOSI]; // (R1) (R3)
   assign fault = mst & (mode_q == sps_pkg::SEL_4WIRE_IN) & nss_fall; // (R10)
   assign done = fall & (cnt_q == 3'(sps_pkg::BYTE_BITS - 1));
   assign load_sh = txb_full_q & (~sh_full_q | done) & ((cnt_q == 3'h0) | done);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sck_d_q <= 1'b0;
         // Same level as the synchroniser after reset, so no false select fall
         nss_d_q <= 1'b0;
      end else begin
         sck_d_q <= sck_s;
         nss_d_q <= nss_s;
      end
   end

   // Hardware fault beats a same-cycle software write of the enables
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         port_en_q <= sps_pkg::PORT_EN_RST;
         mst_en_q <= sps_pkg::MASTER_EN_RST;
         mode_q <= sps_pkg::SEL_MODE_RST;
      end else if (fault) begin
         port_en_q <= 1'b0; // (R14)
         mst_en_q <= 1'b0; // (R14)
      end else if (cfg_wr) begin
         port_en_q <= cfg_port_enable;
         mst_en_q <= cfg_master_enable;
         mode_q <= cfg_select_mode;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mode_fault_flag_q <= sps_pkg::MODE_FAULT_RST;
      end else if (fault) begin
         mode_fault_flag_q <= 1'b1; // (R14)
      end else if (mode_fault_clr) begin
         mode_fault_flag_q <= 1'b0;
      end
   end

   // Write while buffer full is dropped, not queued
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         txb_q <= 8'h00;
         txb_full_q <= 1'b0;
         txr_q <= 1'b1;
      end else if (load_sh) begin
         txb_full_q <= 1'b0;
         txr_q <= 1'b1;
      end else if (tx_load & ~txb_full_q) begin
         txb_q <= tx_data;
         txb_full_q <= 1'b1;
         txr_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         div_q <= 16'h0000;
         sck_q <= 1'b0;
      end else if (~mst | ~sh_full_q) begin
         div_q <= 16'h0000;
         sck_q <= 1'b0;
      end else if (m_wrap) begin
         div_q <= 16'h0000;
         sck_q <= ~sck_q; // (R6)
      end else begin
         div_q <= div_q + 16'h0001;
      end
   end

   // Bit counter only restarts on a select fall or a disable: 3-wire has no resync
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 3'h0;
      end else if (~port_en_q) begin
         cnt_q <= 3'h0;
      end else if (slv & (mode_q == sps_pkg::SEL_4WIRE_IN) & nss_fall) begin
         cnt_q <= 3'h0; // (R15)
      end else if (fall) begin
         cnt_q <= cnt_q + 3'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sh_q <= 8'h00;
         sh_full_q <= 1'b0;
         bit_q <= 1'b0;
      end else begin
         if (rise) begin
            bit_q <= din;
         end
         if (load_sh) begin
            sh_q <= txb_q;
            sh_full_q <= 1'b1;
         end else if (done) begin
            sh_q <= {sh_q[6:0], bit_q}; // (R2)
            sh_full_q <= 1'b0;
         end else if (fall) begin
            sh_q <= {sh_q[6:0], bit_q}; // (R2)
         end
         if (~port_en_q) begin
            sh_full_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rxd_q <= 8'h00;
         rxv_q <= 1'b0;
      end else begin
         rxv_q <= done;
         if (done) begin
            rxd_q <= {sh_q[6:0], bit_q}; // (R2)
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mosi_q <= 1'b0;
         miso_q <= 1'b0;
         mosi_oe_n_q <= 1'b1;
         miso_oe_n_q <= 1'b1;
         sck_oe_n_q <= 1'b1;
         nss_q <= 1'b1;
         nss_oe_n_q <= 1'b1;
         routed_q <= 1'b1;
      end else begin
         mosi_q <= sh_q[7]; // (R2)
         miso_q <= sh_q[7]; // (R5)
         mosi_oe_n_q <= ~mst; // (R1)
         miso_oe_n_q <= ~(slv & sel); // (R3) (R4)
         sck_oe_n_q <= ~mst; // (R6)
         nss_q <= mode_q[sps_pkg::MODE_LO_BIT]; // (R11)
         nss_oe_n_q <= ~mode_q[sps_pkg::MODE_HI_BIT]; // (R11)
         routed_q <= (mode_q != sps_pkg::SEL_3WIRE); // (R12)
      end
   end

   assign port_enable_bit = port_en_q;
   assign master_enable_bit = mst_en_q;
   assign select_mode_field = mode_q;
   assign mode_fault_flag = mode_fault_flag_q;
   assign tx_ready = txr_q;
   assign rx_data = rxd_q;
   assign rx_valid = rxv_q;
   assign mosi_o = mosi_q;
   assign mosi_oe_n = mosi_oe_n_q;
   assign miso_o = miso_q;
   assign miso_oe_n = miso_oe_n_q;
   assign sck_o = sck_q;
   assign sck_oe_n = sck_oe_n_q;
   assign nss_o = nss_q;
   assign nss_oe_n = nss_oe_n_q;
   assign nss_routed = routed_q;

   a_mosi_dir: assert property (@(posedge clk_sys) disable iff (!rstn)
      ##1 mosi_oe_n == !$past(mst)) else $error("data-out direction wrong"); // (R1)
   a_miso_dir: assert property (@(posedge clk_sys) disable iff (!rstn)
      ##1 miso_oe_n == !$past(slv & sel)) else $error("data-in drive wrong"); // (R3)
   a_miso_off: assert property (@(posedge clk_sys) disable iff (!rstn)
      !port_en_q |=> miso_oe_n) else $error("data-in driven while disabled"); // (R4)
   a_miso_msb: assert property (@(posedge clk_sys) disable iff (!rstn)
      (slv && mode_q == 2'h0) |=> miso_o == $past(sh_q[7])) else $error("data-in not top bit"); // (R5)
   a_sck_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
      !mst |=> !sck_o) else $error("serial clock toggles when not master"); // (R6)
   a_ignore_sck: assert property (@(posedge clk_sys) disable iff (!rstn)
      (slv && mode_q == 2'h1 && nss_s) |=> $stable(cnt_q) && $stable(bit_q))
      else $error("clock taken unselected"); // (R7)
   a_fault_act: assert property (@(posedge clk_sys) disable iff (!rstn)
      fault |=> !port_enable_bit && !master_enable_bit && mode_fault_flag) else $error("fault not handled"); // (R14)
   a_nss_out: assert property (@(posedge clk_sys) disable iff (!rstn)
      mode_q[1] ##1 mode_q[1] |-> !nss_oe_n && nss_o == $past(mode_q[0])) else $error("select output wrong"); // (R11)
   a_route: assert property (@(posedge clk_sys) disable iff (!rstn)
      ##1 nss_routed == ($past(mode_q) != 2'h0)) else $error("select routing wrong"); // (R12)
   a_cnt_clr: assert property (@(posedge clk_sys) disable iff (!rstn)
      (slv && mode_q == 2'h1 && nss_fall) |=> cnt_q == 3'h0) else $error("counter not reset"); // (R15)
   a_master_only: assert property (@(posedge clk_sys) disable iff (!rstn)
      !mst_en_q |-> !m_wrap) else $error("master clock without enable"); // (R16)
   c_byte_done: cover property (@(posedge clk_sys) disable iff (!rstn) mst && done);
   c_slave_byte: cover property (@(posedge clk_sys) disable iff (!rstn) slv && done);
   c_fault: cover property (@(posedge clk_sys) disable iff (!rstn) fault);
endmodule
`default_nettype wire

// ### sps_peer.sv
`timescale 1ns/1ps
`default_nettype none
module sps_peer (
   input wire logic clk_sys,
   input wire logic sck,
   input wire logic mosi,
   input wire logic miso,
   output logic sck_m,
   output logic mosi_m,
   output logic nss_m,
   output logic miso_s
);
   logic [7:0] sh_q;
   logic [7:0] rx_q;
   initial begin
      sck_m = 1'b0;
      mosi_m = 1'b0;
      nss_m = 1'b1;
      sh_q = 8'h00;
      rx_q = 8'h00;
   end
   assign miso_s = sh_q[7];
   always @(posedge sck) rx_q <= {rx_q[6:0], mosi};
   // Refill inverts, so a stale bit never looks valid
   always @(negedge sck) sh_q <= {sh_q[6:0], ~sh_q[0]};
   task automatic load(input logic [7:0] v);
      sh_q = v;
   endtask
   // Clock stands low between frames; data inverts when released
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         mosi_m = tx[7 - i];
         repeat (4) @(negedge clk_sys);
         sck_m = 1'b1;
         rx = {rx[6:0], miso};
         repeat (4) @(negedge clk_sys);
         sck_m = 1'b0;
      end
      mosi_m = ~mosi_m;
   endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_sys, rstn, cfg_wr, cfg_pe, cfg_me, mode_fault_clr, tx_load;
   logic [1:0] cfg_md;
   logic [7:0] tx_data, rx_data, rx_last, r;
   logic pe_b, me_b, fault, tx_ready, rx_valid, nss_routed;
   logic [1:0] md_f;
   logic mosi_o, mosi_oe_n, miso_o, miso_oe_n, sck_o, sck_oe_n, nss_o, nss_oe_n;
   logic sck_m, mosi_m, nss_m, miso_s, mosi_w, miso_w, sck_w, nss_w;
   int fails, samples_checked, rx_cnt, n0;
   // Peer is the only other device on the bus: slave while the DUT is master, master while the DUT is slave
   assign mosi_w = !mosi_oe_n ? mosi_o : mosi_m;
   assign miso_w = !miso_oe_n ? miso_o : miso_s;
   assign sck_w = !sck_oe_n ? sck_o : sck_m;
   assign nss_w = !nss_oe_n ? nss_o : nss_m;
   sps_port dut (.clk_sys(clk_sys), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_port_enable(cfg_pe),
      .cfg_master_enable(cfg_me), .cfg_select_mode(cfg_md), .mode_fault_clr(mode_fault_clr),
      .port_enable_bit(pe_b), .master_enable_bit(me_b), .select_mode_field(md_f),
      .mode_fault_flag(fault), .tx_load(tx_load), .tx_data(tx_data), .tx_ready(tx_ready),
      .rx_data(rx_data), .rx_valid(rx_valid), .mosi_i(mosi_w), .mosi_o(mosi_o),
      .mosi_oe_n(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
      .sck_i(sck_w), .sck_o(sck_o), .sck_oe_n(sck_oe_n), .nss_i(nss_w), .nss_o(nss_o),
      .nss_oe_n(nss_oe_n), .nss_routed(nss_routed));
   sps_peer peer (.clk_sys(clk_sys), .sck(sck_w), .mosi(mosi_w), .miso(miso_w),
      .sck_m(sck_m), .mosi_m(mosi_m), .nss_m(nss_m), .miso_s(miso_s));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(negedge clk_sys) if (rx_valid === 1'b1) begin
      rx_cnt++;
      rx_last = rx_data;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic cfg(input logic pe, input logic me, input logic [1:0] md);
      @(negedge clk_sys);
      cfg_wr = 1'b1;
      cfg_pe = pe;
      cfg_me = me;
      cfg_md = md;
      cyc(1);
      cfg_wr = 1'b0;
      cyc(3);
   endtask
   task automatic wait_cnt(input int n);
      for (int k = 0; k < 300 && rx_cnt < n; k++) cyc(1);
      if (rx_cnt < n) begin
         fails++;
         $display("MISMATCH t=%0t receive wait ran out", $time);
      end
   endtask
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #200000;
      fails++;
      give_verdict();
   end
   initial begin
      {rstn, cfg_wr, cfg_pe, cfg_me, mode_fault_clr, tx_load} = 6'h00;
      cfg_md = 2'h0;
      tx_data = 8'h00;
      {fails, samples_checked, rx_cnt} = '0;
      cyc(10);
      rstn = 1'b1;
      cyc(2);
      chk(miso_oe_n, 1'b1);
      chk({md_f, pe_b, me_b}, 4'h4);
      chk(nss_routed, 1'b1);
      cfg(1'b1, 1'b1, 2'h0);
      chk({mosi_oe_n, miso_oe_n, sck_oe_n}, 3'h2);
      chk(nss_routed, 1'b0);
      peer.load(8'h3C);
      tx_data = 8'hA5;
      tx_load = 1'b1;
      cyc(1);
      tx_load = 1'b0;
      wait_cnt(1);
      chk(rx_last, 8'h3C);
      chk(peer.rx_q, 8'hA5);
      chk(rx_cnt, 1);
      for (int m = 2; m < 4; m++) begin
         cfg(1'b1, 1'b1, m[1:0]);
         chk({nss_oe_n, nss_o, nss_routed}, {1'b0, m[0], 1'b1});
      end
      cfg(1'b1, 1'b0, 2'h0);
      chk({mosi_oe_n, miso_oe_n, sck_oe_n}, 3'h5);
      tx_data = 8'h96;
      tx_load = 1'b1;
      cyc(1);
      tx_load = 1'b0;
      cyc(4);
      chk({tx_ready, miso_o}, 2'h3);
      peer.xfer(8'h5A, 8, r);
      chk(r, 8'h96);
      wait_cnt(2);
      chk(rx_last, 8'h5A);
      peer.nss_m = 1'b1;
      cfg(1'b1, 1'b0, 2'h1);
      chk({miso_oe_n, nss_routed}, 2'h3);
      n0 = rx_cnt;
      peer.xfer(8'hFF, 8, r);
      cyc(10);
      chk(rx_cnt, n0);
      peer.nss_m = 1'b0;
      cyc(4);
      chk(miso_oe_n, 1'b0);
      peer.xfer(8'h11, 3, r);
      peer.nss_m = 1'b1;
      cyc(4);
      peer.nss_m = 1'b0;
      cyc(4);
      peer.xfer(8'hC3, 8, r);
      wait_cnt(n0 + 1);
      chk(rx_last, 8'hC3);
      peer.nss_m = 1'b1;
      cfg(1'b1, 1'b1, 2'h1);
      chk({pe_b, me_b, fault}, 3'h6);
      peer.nss_m = 1'b0;
      cyc(6);
      chk({pe_b, me_b, fault}, 3'h1);
      chk(mosi_oe_n, 1'b1);
      mode_fault_clr = 1'b1;
      cyc(1);
      mode_fault_clr = 1'b0;
      cyc(1);
      chk(fault, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
